// ### logic/servo_node_pkg.sv
// Constants shared by the servo node network logic.
// Assumes a 40 MHz system clock and an 8N1 serial frame on the link.
`default_nettype none
package servo_node_pkg;
    // Clock rate and serial timing.
    localparam int unsigned CLK_HZ   = 40_000_000;
    localparam int unsigned BAUD     = 115_200;
    localparam int unsigned BIT_CYC  = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYC = BIT_CYC / 2;
    localparam int unsigned GAP_BITS = 20;
    localparam int unsigned GAP_CYC  = GAP_BITS * BIT_CYC;
    // Drive period timing.
    localparam int unsigned PWM_HZ   = 20_000;
    localparam int unsigned PWM_CYC  = CLK_HZ / PWM_HZ;
    // Addressing.
    localparam int unsigned MAX_NODES = 32;
    localparam logic [7:0]  ADDR_RST  = 8'h00;
    // Command codes carried in the second byte of a frame.
    localparam logic [7:0] CMD_SET_ADDR = 8'h01;
    localparam logic [7:0] CMD_SET_DUTY = 8'h02;
    localparam logic [7:0] CMD_SET_CTRL = 8'h03;
    localparam logic [7:0] CMD_RD_ADC   = 8'h04;
    localparam logic [7:0] CMD_RD_POS_L = 8'h05;
    localparam logic [7:0] CMD_RD_POS_H = 8'h06;
    localparam logic [7:0] CMD_SET_ILIM = 8'h07;
    // Control byte fields and reset values.
    localparam int unsigned CTRL_AMP_BIT = 0;
    localparam int unsigned CTRL_DIR_BIT = 1;
    localparam int unsigned CTRL_ILE_BIT = 2;
    localparam logic [7:0]  DUTY_RST     = 8'h00;
    localparam logic [7:0]  ILIM_RST     = 8'hff;
    // Serial engine states.
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_START = 2'b01,
        SER_DATA  = 2'b10,
        SER_STOP  = 2'b11
    } ser_st_t;
endpackage
`default_nettype wire

// ### logic/servo_node.sv
// Network, drive and position logic of one multidrop servo node.
// Assumes all inputs are synchronous to i_clk and the transceiver follows o_txd_oe.
// Functional notes
// - Host drives a private command line; nodes share one reply line.
// - Up to 32 nodes share the host port through chained addressing.
// - Select input high keeps node deaf and off the reply line.
// - Address is 0 after reset; only a selected node answers there.
// - Changing the address from default drives chain select output low.
// - Drive output is 20 kHz PWM with a separate direction output.
// - An amplifier enable output switches the external amplifier.
// - Analog input sampled as unsigned 8-bit value readable by command.
// - Sampled current above the limit blanks the drive output.
// - Link runs at one fixed rate up to 115200 baud.
// - Quadrature counting runs in its own unit; servo logic reads it.
// - Amplifier enable is active high.
`timescale 1ns/1ps
`default_nettype none
module servo_node (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // Serial link.
    input  wire logic i_rxd,
    output var  logic o_txd,
    output var  logic o_txd_oe,
    // Address chain.
    input  wire logic i_sel_n,
    output var  logic o_sel_out_n,
    // Amplifier.
    output var  logic o_pwm,
    output var  logic o_dir,
    output var  logic o_amp_en,
    // Analog sample and encoder.
    input  wire logic [7:0] i_adc_data,
    input  wire logic       i_adc_valid,
    input  wire logic       i_enc_a,
    input  wire logic       i_enc_b
);
    import servo_node_pkg::*;

    localparam logic [8:0]  BIT_C  = 9'(BIT_CYC - 1);
    localparam logic [8:0]  HALF_C = 9'(HALF_CYC - 1);
    localparam logic [12:0] GAP_C  = 13'(GAP_CYC);
    localparam logic [10:0] PWM_C  = 11'(PWM_CYC - 1);

    // Receiver state.
    ser_st_t     rx_st_q, rx_st_d;
    logic [8:0]  rx_cnt_q, rx_cnt_d;
    logic [2:0]  rx_bit_q, rx_bit_d;
    logic [7:0]  rx_sh_q, rx_sh_d;
    logic        rx_vld_q, rx_vld_d;

    // Receiver: samples mid-bit at the fixed link rate.
    always_comb begin
        rx_st_d  = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d  = rx_sh_q;
        rx_vld_d = 1'b0;
        case (rx_st_q)
            SER_IDLE: begin
                if (!i_rxd) begin
                    rx_st_d  = SER_START;
                    rx_cnt_d = HALF_C;
                end
            end
            SER_START: begin
                if (rx_cnt_q != 9'h000) begin
                    rx_cnt_d = rx_cnt_q - 9'h001;
                end else if (i_rxd) begin
                    rx_st_d = SER_IDLE; // A glitch, not a start bit.
                end else begin
                    rx_st_d  = SER_DATA;
                    rx_cnt_d = BIT_C;
                    rx_bit_d = 3'h0;
                end
            end
            SER_DATA: begin
                if (rx_cnt_q != 9'h000) begin
                    rx_cnt_d = rx_cnt_q - 9'h001;
                end else begin
                    rx_sh_d  = {i_rxd, rx_sh_q[7:1]};
                    rx_cnt_d = BIT_C;
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == 3'h7) begin
                        rx_st_d = SER_STOP;
                    end
                end
            end
            SER_STOP: begin
                if (rx_cnt_q != 9'h000) begin
                    rx_cnt_d = rx_cnt_q - 9'h001;
                end else begin
                    rx_st_d  = SER_IDLE;
                    rx_vld_d = i_rxd; // A bad stop bit drops the byte.
                end
            end
            default: rx_st_d = SER_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rx_st_q  <= SER_IDLE;
            rx_cnt_q <= 9'h000;
            rx_bit_q <= 3'h0;
            rx_sh_q  <= 8'h00;
            rx_vld_q <= 1'b0;
        end else begin
            rx_st_q  <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q  <= rx_sh_d;
            rx_vld_q <= rx_vld_d;
        end
    end

    // Quadrature counting unit, kept apart from command handling.
    logic [1:0]  enc_q, enc_d;
    logic [15:0] pos_q, pos_d;

    // Each valid Gray step moves the count by one; double steps are ignored.
    always_comb begin
        enc_d = {i_enc_a, i_enc_b};
        pos_d = pos_q;
        case ({enc_q, enc_d})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: pos_d = pos_q + 16'h0001;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: pos_d = pos_q - 16'h0001;
            default: pos_d = pos_q;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            enc_q <= 2'b00;
            pos_q <= 16'h0000;
        end else begin
            enc_q <= enc_d;
            pos_q <= pos_d;
        end
    end

    // Command state.
    logic [1:0]  idx_q, idx_d;
    logic [12:0] gap_q, gap_d;
    logic [7:0]  fa_q, fa_d;
    logic [7:0]  fc_q, fc_d;
    logic [7:0]  addr_q, addr_d;
    logic        sel_out_n_q, sel_out_n_d;
    logic [7:0]  duty_q, duty_d;
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  ilim_q, ilim_d;
    logic [7:0]  adc_q, adc_d;
    logic        rep_go_q, rep_go_d;
    logic [7:0]  rep_q, rep_d;

    // Frame is address, command, data; a long gap restarts framing.
    always_comb begin
        idx_d       = idx_q;
        gap_d       = gap_q;
        fa_d        = fa_q;
        fc_d        = fc_q;
        addr_d      = addr_q;
        sel_out_n_d = sel_out_n_q;
        duty_d      = duty_q;
        ctrl_d      = ctrl_q;
        ilim_d      = ilim_q;
        adc_d       = i_adc_valid ? i_adc_data : adc_q;
        rep_go_d    = 1'b0;
        rep_d       = rep_q;
        if (gap_q != 13'h0000) begin
            gap_d = gap_q - 13'h0001;
        end else begin
            idx_d = 2'h0;
        end
        if (i_sel_n) begin
            idx_d = 2'h0; // A deselected node hears nothing.
        end else if (rx_vld_q) begin
            gap_d = GAP_C;
            case (idx_q)
                2'h0: begin
                    fa_d  = rx_sh_q;
                    idx_d = 2'h1;
                end
                2'h1: begin
                    fc_d  = rx_sh_q;
                    idx_d = 2'h2;
                end
                default: begin
                    idx_d = 2'h0;
                    if (fa_q == addr_q) begin
                        rep_go_d = 1'b1;
                        rep_d    = addr_q;
                        case (fc_q)
                            CMD_SET_ADDR: begin
                                addr_d = rx_sh_q;
                                rep_d  = rx_sh_q;
                                if (rx_sh_q != ADDR_RST) begin
                                    sel_out_n_d = 1'b0; // Frees the next node.
                                end
                            end
                            CMD_SET_DUTY: duty_d = rx_sh_q;
                            CMD_SET_CTRL: ctrl_d = rx_sh_q;
                            CMD_SET_ILIM: ilim_d = rx_sh_q;
                            CMD_RD_ADC:   rep_d  = adc_q;
                            CMD_RD_POS_L: rep_d  = pos_q[7:0];
                            CMD_RD_POS_H: rep_d  = pos_q[15:8];
                            default:      rep_go_d = 1'b0;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            idx_q       <= 2'h0;
            gap_q       <= 13'h0000;
            fa_q        <= 8'h00;
            fc_q        <= 8'h00;
            addr_q      <= ADDR_RST;
            sel_out_n_q <= 1'b1;
            duty_q      <= DUTY_RST;
            ctrl_q      <= 8'h00;
            ilim_q      <= ILIM_RST;
            adc_q       <= 8'h00;
            rep_go_q    <= 1'b0;
            rep_q       <= 8'h00;
        end else begin
            idx_q       <= idx_d;
            gap_q       <= gap_d;
            fa_q        <= fa_d;
            fc_q        <= fc_d;
            addr_q      <= addr_d;
            sel_out_n_q <= sel_out_n_d;
            duty_q      <= duty_d;
            ctrl_q      <= ctrl_d;
            ilim_q      <= ilim_d;
            adc_q       <= adc_d;
            rep_go_q    <= rep_go_d;
            rep_q       <= rep_d;
        end
    end

    // Transmitter state.
    ser_st_t     tx_st_q, tx_st_d;
    logic [8:0]  tx_cnt_q, tx_cnt_d;
    logic [2:0]  tx_bit_q, tx_bit_d;
    logic [7:0]  tx_sh_q, tx_sh_d;
    logic        txd_q, txd_d;
    logic        oe_q, oe_d;

    // Replies go on the shared line; the driver is on only for the reply frame.
    always_comb begin
        tx_st_d  = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d  = tx_sh_q;
        txd_d    = txd_q;
        oe_d     = oe_q;
        if (tx_st_q != SER_IDLE && tx_cnt_q != 9'h000) begin
            tx_cnt_d = tx_cnt_q - 9'h001;
        end else begin
            tx_cnt_d = BIT_C;
            case (tx_st_q)
                SER_IDLE: begin
                    txd_d = 1'b1;
                    oe_d  = 1'b0;
                    // A reply due while one is still going out is dropped.
                    if (rep_go_q && !i_sel_n) begin
                        tx_st_d = SER_START;
                        tx_sh_d = rep_q;
                        txd_d   = 1'b0;
                        oe_d    = 1'b1;
                    end
                end
                SER_START: begin
                    tx_st_d  = SER_DATA;
                    tx_bit_d = 3'h0;
                    txd_d    = tx_sh_q[0];
                end
                SER_DATA: begin
                    tx_bit_d = tx_bit_q + 3'h1;
                    tx_sh_d  = {1'b1, tx_sh_q[7:1]};
                    txd_d    = tx_sh_q[1];
                    if (tx_bit_q == 3'h7) begin
                        tx_st_d = SER_STOP;
                        txd_d   = 1'b1;
                    end
                end
                SER_STOP: begin
                    tx_st_d = SER_IDLE;
                    oe_d    = 1'b0;
                end
                default: tx_st_d = SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tx_st_q  <= SER_IDLE;
            tx_cnt_q <= 9'h000;
            tx_bit_q <= 3'h0;
            tx_sh_q  <= 8'h00;
            txd_q    <= 1'b1;
            oe_q     <= 1'b0;
        end else begin
            tx_st_q  <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q  <= tx_sh_d;
            txd_q    <= txd_d;
            oe_q     <= oe_d;
        end
    end

    // Drive state.
    logic [10:0] pwm_cnt_q, pwm_cnt_d;
    logic        blank_q, blank_d;
    logic        pwm_q, pwm_d;
    logic        dir_q, dir_d;
    logic        amp_q, amp_d;

    // Duty times eight sets the high time, so duties from 250 up give 100 percent.
    always_comb begin
        pwm_cnt_d = (pwm_cnt_q == PWM_C) ? 11'h000 : pwm_cnt_q + 11'h001;
        blank_d   = blank_q;
        // Overcurrent blanks the rest of the period; it wins over the period-end clear,
        // so blanking holds until the first period end that comes with no fault.
        if (ctrl_q[CTRL_ILE_BIT] && adc_q > ilim_q) begin
            blank_d = 1'b1;
        end else if (pwm_cnt_q == PWM_C) begin
            blank_d = 1'b0;
        end
        pwm_d = (pwm_cnt_q < {duty_q, 3'b000}) && !blank_d && ctrl_q[CTRL_AMP_BIT];
        dir_d = ctrl_q[CTRL_DIR_BIT];
        amp_d = ctrl_q[CTRL_AMP_BIT]; // One enables the amplifier.
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pwm_cnt_q <= 11'h000;
            blank_q   <= 1'b0;
            pwm_q     <= 1'b0;
            dir_q     <= 1'b0;
            amp_q     <= 1'b0;
        end else begin
            pwm_cnt_q <= pwm_cnt_d;
            blank_q   <= blank_d;
            pwm_q     <= pwm_d;
            dir_q     <= dir_d;
            amp_q     <= amp_d;
        end
    end

    // All outputs come straight from flip-flops.
    assign o_txd       = txd_q;
    assign o_txd_oe    = oe_q;
    assign o_sel_out_n = sel_out_n_q;
    assign o_pwm       = pwm_q;
    assign o_dir       = dir_q;
    assign o_amp_en    = amp_q;
endmodule // servo_node
`default_nettype wire

// ### test/servo_node_props.sv
// Concurrent checks on the ports of the servo node.
// Assumes binding to servo_node and one clock domain with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module servo_node_props
    import servo_node_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Watched ports.
    input wire logic i_sel_n,
    input wire logic o_txd,
    input wire logic o_txd_oe,
    input wire logic o_sel_out_n,
    input wire logic o_pwm,
    input wire logic o_dir,
    input wire logic o_amp_en
);
    localparam int OE_LEN = 10 * BIT_CYC;
    logic [15:0] oe_cnt_q;
    logic [15:0] oe_cnt_d;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Length of the current reply drive; a long reply would wrap only after 65536 cycles.
    always_comb begin
        oe_cnt_d = o_txd_oe ? oe_cnt_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge i_clk) begin
        oe_cnt_q <= i_sys_rst ? 16'h0000 : oe_cnt_d;
    end

    // Reply line ownership, address chain and drive gating.
    chk_rst_quiet: assert property ($fell(i_sys_rst) |-> o_txd && !o_txd_oe && o_sel_out_n
        && !o_amp_en && !o_dir && !o_pwm) else $error("outputs not quiet after reset");
    chk_deaf_silent: assert property (i_sel_n [*8] |-> !$rose(o_txd_oe))
        else $error("deselected node started a reply");
    chk_reply_len: assert property ($fell(o_txd_oe) |-> oe_cnt_q == OE_LEN)
        else $error("reply drive length wrong");
    chk_idle_high: assert property (!o_txd_oe |-> o_txd)
        else $error("reply data not idle high");
    chk_sel_hold: assert property (!o_sel_out_n |=> !o_sel_out_n)
        else $error("chain select output released");
    chk_sel_cause: assert property ($fell(o_sel_out_n) |-> !$past(i_sel_n)
        ##[1:3] $rose(o_txd_oe)) else $error("chain select output fell without a reply");
    // The output follows the control byte in the same clock as the reply starts its driver.
    chk_amp_cause: assert property ($changed(o_amp_en) |-> $rose(o_txd_oe))
        else $error("amplifier enable moved without a command");
    chk_dir_cause: assert property ($changed(o_dir) |-> $rose(o_txd_oe))
        else $error("direction moved without a command");
    chk_pwm_gate: assert property (!o_amp_en [*3] |-> !o_pwm)
        else $error("drive pulses while amplifier disabled");
endmodule // servo_node_props
`default_nettype wire

// ### test/host_link_model.sv
// Host serial port behind a line converter, seen from the node's serial pins.
// Assumes callers enter its tasks just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_link_model
    import servo_node_pkg::*;
(
    // Clock and node reply pins.
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic i_txd_oe,
    // Private host command line.
    output var logic o_cmd_line
);
    logic line;

    // The shared reply pair is biased to idle when no node drives it.
    assign line = i_txd_oe ? i_txd : 1'b1;
    initial o_cmd_line = 1'b1;

    // One 8N1 byte, LSB first, at the node's fixed rate.
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_cmd_line = fr[i];
            repeat (BIT_CYC) @(negedge i_clk);
        end
    endtask

    // Waits a bounded time for a reply byte, sampling mid-bit.
    task automatic get_reply(input int limit, output logic [7:0] b, output logic got);
        got = 1'b0;
        b = 8'h00;
        for (int n = 0; n < limit && !got; n++) begin
            @(negedge i_clk);
            got = (line === 1'b0);
        end
        if (got) begin
            repeat (HALF_CYC) @(negedge i_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(negedge i_clk);
                b[i] = line;
            end
            repeat (BIT_CYC) @(negedge i_clk);
            got = (line === 1'b1);
        end
    endtask

    // Sends one 3-byte frame and listens for the reply meanwhile, since it starts mid stop bit.
    task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                        output logic [7:0] rep, output logic got);
        fork
            begin
                send_byte(a);
                send_byte(c);
                send_byte(d);
            end
            get_reply(32 * BIT_CYC, rep, got);
        join
    endtask
endmodule // host_link_model
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the servo node with a host link model.
// Assumes the package constants; the bench steps the encoder inputs itself.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import servo_node_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_sys_rst = 1'b1;
    logic       i_rxd;
    logic       i_sel_n = 1'b1;
    logic [7:0] i_adc_data = 8'h00;
    logic       i_adc_valid = 1'b0;
    logic       i_enc_a = 1'b0;
    logic       i_enc_b = 1'b0;
    logic [1:0] enc_ph = 2'h0;
    logic       o_txd;
    logic       o_txd_oe;
    logic       o_sel_out_n;
    logic       o_pwm;
    logic       o_dir;
    logic       o_amp_en;
    logic [7:0] rep;
    logic       got;
    int         num_errors = 0;
    int         checks_done = 0;

    // 40 MHz system clock.
    always #12.5 i_clk = ~i_clk;

    servo_node dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rxd(i_rxd), .o_txd(o_txd),
        .o_txd_oe(o_txd_oe), .i_sel_n(i_sel_n), .o_sel_out_n(o_sel_out_n), .o_pwm(o_pwm),
        .o_dir(o_dir), .o_amp_en(o_amp_en), .i_adc_data(i_adc_data), .i_adc_valid(i_adc_valid),
        .i_enc_a(i_enc_a), .i_enc_b(i_enc_b));
    host_link_model host_u (.i_clk(i_clk), .i_txd(o_txd), .i_txd_oe(o_txd_oe),
        .o_cmd_line(i_rxd));

    // Compares one value and reports a mismatch at once.
    task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string what);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, g, e);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A deselected node must ignore even a valid address assignment.
    task automatic t_deaf;
        i_sel_n = 1'b1;
        host_u.xfer(ADDR_RST, CMD_SET_ADDR, 8'h1f, rep, got);
        cmp({7'h00, got}, 8'h00, "deaf reply");
        cmp({7'h00, o_sel_out_n}, 8'h01, "deaf chain");
        $display("t_deaf done");
    endtask

    // Selected node takes the highest address and releases the next node.
    task automatic t_assign;
        i_sel_n = 1'b0;
        host_u.xfer(ADDR_RST, CMD_SET_ADDR, 8'(MAX_NODES - 1), rep, got);
        cmp({7'h00, got}, 8'h01, "assign reply");
        cmp(rep, 8'h1f, "assign data");
        cmp({7'h00, o_sel_out_n}, 8'h00, "chain out");
        host_u.xfer(ADDR_RST, CMD_SET_CTRL, 8'h03, rep, got);
        cmp({7'h00, got}, 8'h00, "old address reply");
        cmp({7'h00, o_amp_en}, 8'h00, "old address ctrl");
        $display("t_assign done");
    endtask

    // Control byte drives enable, direction and limit; duty 25 gives 200 high cycles.
    task automatic t_drive;
        int n;
        int hi;
        int per;
        host_u.xfer(8'h1f, CMD_SET_CTRL, 8'h07, rep, got);
        cmp(rep, 8'h1f, "ctrl reply");
        cmp({6'h00, o_dir, o_amp_en}, 8'h03, "ctrl outs");
        host_u.xfer(8'h1f, CMD_SET_DUTY, 8'h19, rep, got);
        cmp(rep, 8'h1f, "duty reply");
        n = 0;
        hi = 0;
        per = 0;
        while (o_pwm !== 1'b0 && n < 5000) begin @(negedge i_clk); n++; end
        while (o_pwm !== 1'b1 && n < 5000) begin @(negedge i_clk); n++; end
        while (o_pwm === 1'b1 && n < 5000) begin @(negedge i_clk); n++; hi++; end
        per = hi;
        while (o_pwm !== 1'b1 && n < 5000) begin @(negedge i_clk); n++; per++; end
        if (n >= 5000) begin
            num_errors++;
            $display("[FAIL] %0t drive output stuck", $time);
            results();
        end
        cmp(8'(hi), 8'(25 * 8), "pwm high");
        cmp(8'(per / 8), 8'(PWM_CYC / 8), "pwm period");
        $display("t_drive done");
    endtask

    // A strobed sample is returned even after the live input moves on.
    task automatic t_adc;
        i_adc_data = 8'ha7;
        i_adc_valid = 1'b1;
        @(negedge i_clk);
        i_adc_valid = 1'b0;
        i_adc_data = 8'h3c;
        host_u.xfer(8'h1f, CMD_RD_ADC, 8'h00, rep, got);
        cmp(rep, 8'ha7, "sample");
        $display("t_adc done");
    endtask

    // A held sample above the limit keeps the drive dark; a low one frees the next period.
    task automatic t_ilim;
        int hi;
        host_u.xfer(8'h1f, CMD_SET_ILIM, 8'h40, rep, got);
        cmp(rep, 8'h1f, "ilim reply");
        hi = 0;
        repeat (2100) begin
            @(negedge i_clk);
            if (o_pwm === 1'b1) hi++;
        end
        cmp({7'h00, hi != 0}, 8'h00, "blanked");
        i_adc_data = 8'h10;
        i_adc_valid = 1'b1;
        @(negedge i_clk);
        i_adc_valid = 1'b0;
        hi = 0;
        repeat (2300) begin
            @(negedge i_clk);
            if (o_pwm === 1'b1) hi++;
        end
        cmp({7'h00, hi == 25 * 8}, 8'h01, "unblanked");
        $display("t_ilim done");
    endtask

    // Walks the quadrature inputs through Gray steps, four clocks a step.
    task automatic enc_steps(input int cnt, input logic up);
        for (int i = 0; i < cnt; i++) begin
            enc_ph = up ? enc_ph + 2'h1 : enc_ph - 2'h1;
            {i_enc_a, i_enc_b} = {enc_ph[1], enc_ph[1] ^ enc_ph[0]};
            repeat (4) @(negedge i_clk);
        end
    endtask

    // Five steps up then seven down leave the count at minus two.
    task automatic t_pos;
        enc_steps(5, 1'b1);
        host_u.xfer(8'h1f, CMD_RD_POS_L, 8'h00, rep, got);
        cmp(rep, 8'h05, "pos low");
        enc_steps(7, 1'b0);
        host_u.xfer(8'h1f, CMD_RD_POS_H, 8'h00, rep, got);
        cmp(rep, 8'hff, "pos high");
        $display("t_pos done");
    endtask

    // Reset, then the scenarios in order.
    initial begin
        repeat (8) @(negedge i_clk);
        i_sys_rst = 1'b0;
        @(negedge i_clk);
        cmp({2'h0, o_dir, o_txd, o_txd_oe, o_sel_out_n, o_amp_en, o_pwm}, 8'h14,
            "reset");
        t_deaf();
        t_assign();
        t_drive();
        t_adc();
        t_ilim();
        t_pos();
        results();
    end
endmodule // testbench

bind servo_node servo_node_props chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_sel_n(i_sel_n), .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_sel_out_n(o_sel_out_n),
    .o_pwm(o_pwm), .o_dir(o_dir), .o_amp_en(o_amp_en));
`default_nettype wire
